// ===== rtl/cdma_pkg.sv
// Constants, types and register map of the card socket DMA channel.
// Assumes a 100 MHz clock shared with the AXI4-Lite register bus.
package cdma_pkg;

   // ==========================================================
   // Register map (index; byte address is four times the index)
   // ==========================================================
   localparam logic [5:0] IDX_CUR_ADDR = 6'h00;
   localparam logic [5:0] IDX_PAGE = 6'h02;
   localparam logic [5:0] IDX_CUR_CNT = 6'h04;
   localparam logic [5:0] IDX_STATUS = 6'h08;
   localparam logic [5:0] IDX_SW_REQ = 6'h09;
   localparam logic [5:0] IDX_MODE = 6'h0B;
   localparam logic [5:0] IDX_MCLR = 6'h0D;
   localparam logic [5:0] IDX_MASK = 6'h0F;
   localparam logic [5:0] IDX_CFG = 6'h10;

   // ==========================================================
   // Field positions and reset values
   // ==========================================================
   localparam int CMD_DIS_BIT = 2;
   localparam int CFG_WIDE_BIT = 0;
   localparam int MASK_BIT = 0;
   localparam int MODE_SEL_LSB = 6;
   localparam int MODE_DEC_BIT = 5;
   localparam int MODE_AUTO_BIT = 4;
   localparam int MODE_TYPE_LSB = 2;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [1:0] {
      MODE_DEMAND = 2'b00,
      MODE_SINGLE = 2'b01,
      MODE_BLOCK = 2'b10,
      MODE_RSVD = 2'b11
   } cdma_mode_t;

   typedef enum logic [1:0] {
      TYPE_NONE = 2'b00,
      TYPE_MEM_WRITE = 2'b01,
      TYPE_MEM_READ = 2'b10,
      TYPE_RSVD = 2'b11
   } cdma_xtype_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ISSUE = 2'b01,
      ST_HOLD = 2'b10
   } cdma_state_t;

   // One transfer offered to the bus-master side.
   typedef struct packed {
      logic [23:0] addr;
      logic toMemory;
      logic wide;
   } cdma_xfer_t;

endpackage

// ===== rtl/cdma_channel.sv
// Register file and sequencer of a single-channel distributed DMA slave.
// Assumes an AXI4-Lite master for the registers, a card request pin and a
// card presence pin from outside the clock domain, and a bus-master engine
// that takes one transfer per xferValid/xferReady handshake.
`timescale 1ns/1ps
`default_nettype none

module cdma_channel
   import cdma_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Card socket pins
   input wire logic cardReq,
   input wire logic cardPresent,
   // Transfer requests to the bus-master engine
   output logic xferValid,
   input wire logic xferReady,
   output cdma_xfer_t xferReq
);

   // ==========================================================
   // State
   // ==========================================================
   logic [2:0] reqSync_q, reqSync_d;
   logic [2:0] presSync_q, presSync_d;
   logic reqF_q, reqF_d;
   logic presF_q, presF_d;
   logic [15:0] curAddr_q, curAddr_d, baseAddr_q, baseAddr_d;
   logic [15:0] curCnt_q, curCnt_d, baseCnt_q, baseCnt_d;
   logic [7:0] page_q, page_d;
   logic cmdDis_q, cmdDis_d;
   logic wide_q, wide_d;
   cdma_mode_t modeSel_q, modeSel_d;
   logic addrDec_q, addrDec_d;
   logic autoReload_q, autoReload_d;
   cdma_xtype_t xtype_q, xtype_d;
   logic mask_q, mask_d;
   logic tc_q, tc_d;
   logic swReq_q, swReq_d;
   cdma_state_t state_q, state_d;
   cdma_xfer_t xfer_q, xfer_d;
   logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
   logic [5:0] awIdx_q, awIdx_d;
   logic [31:0] wData_q, wData_d;
   logic [3:0] wStrb_q, wStrb_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic rvalid_q, rvalid_d;
   logic [1:0] rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;

   // ==========================================================
   // Combinational helpers
   // ==========================================================
   logic wrFire, rdFire, xferDone, effReq, canRun, tcHit, rdStatus, mclr;
   logic [5:0] arIdx;
   logic [15:0] step, nextAddr, nextCnt;

   assign s_axi_awready = !awHeld_q;
   assign s_axi_wready = !wHeld_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign xferValid = (state_q == ST_ISSUE);
   assign xferReq = xfer_q;

   assign wrFire = awHeld_q && wHeld_q && !bvalid_q;
   assign rdFire = s_axi_arvalid && !rvalid_q;
   assign arIdx = s_axi_araddr[7:2];
   assign xferDone = xferValid && xferReady;
   assign effReq = reqF_q && !mask_q;
   assign canRun = !cmdDis_q && (xtype_q == TYPE_MEM_WRITE || xtype_q == TYPE_MEM_READ);
   assign step = wide_q ? STEP_WORD : STEP_BYTE;
   assign tcHit = (curCnt_q <= step);
   assign nextCnt = curCnt_q - step;
   assign nextAddr = addrDec_q ? curAddr_q - step : curAddr_q + step;
   assign rdStatus = rdFire && (arIdx == IDX_STATUS);
   assign mclr = wrFire && (awIdx_q == IDX_MCLR);

   // Builds the transfer descriptor; a word transfer shifts the address left one bit and drops page bit 0.
   function automatic cdma_xfer_t mkXfer(input logic [15:0] a);
      cdma_xfer_t x;
      x.wide = wide_q;
      x.toMemory = (xtype_q == TYPE_MEM_WRITE);
      x.addr = wide_q ? {page_q[7:1], a, 1'b0} : {page_q, a};
      return x;
   endfunction

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      reqSync_d = {reqSync_q[1:0], cardReq};
      presSync_d = {presSync_q[1:0], cardPresent};
      reqF_d = (reqSync_q[1] == reqSync_q[2]) ? reqSync_q[2] : reqF_q;
      presF_d = (presSync_q[1] == presSync_q[2]) ? presSync_q[2] : presF_q;
      curAddr_d = curAddr_q;
      baseAddr_d = baseAddr_q;
      curCnt_d = curCnt_q;
      baseCnt_d = baseCnt_q;
      page_d = page_q;
      cmdDis_d = cmdDis_q;
      wide_d = wide_q;
      modeSel_d = modeSel_q;
      addrDec_d = addrDec_q;
      autoReload_d = autoReload_q;
      xtype_d = xtype_q;
      mask_d = mask_q;
      tc_d = tc_q;
      swReq_d = swReq_q;
      state_d = state_q;
      xfer_d = xfer_q;
      awHeld_d = awHeld_q;
      awIdx_d = awIdx_q;
      wHeld_d = wHeld_q;
      wData_d = wData_q;
      wStrb_d = wStrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;

      // Write channels are taken independently and answered once both are in.
      if (s_axi_awvalid && !awHeld_q) begin
         awHeld_d = 1'b1;
         awIdx_d = s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && !wHeld_q) begin
         wHeld_d = 1'b1;
         wData_d = s_axi_wdata;
         wStrb_d = s_axi_wstrb;
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (wrFire) begin
         awHeld_d = 1'b0;
         wHeld_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = RESP_OKAY;
         unique case (awIdx_q)
            IDX_CUR_ADDR: begin
               if (wStrb_q[0]) begin
                  baseAddr_d[7:0] = wData_q[7:0];
                  curAddr_d[7:0] = wData_q[7:0];
               end
               if (wStrb_q[1]) begin
                  baseAddr_d[15:8] = wData_q[15:8];
                  curAddr_d[15:8] = wData_q[15:8];
               end
            end
            IDX_CUR_CNT: begin
               if (wStrb_q[0]) begin
                  baseCnt_d[7:0] = wData_q[7:0];
                  curCnt_d[7:0] = wData_q[7:0];
               end
               if (wStrb_q[1]) begin
                  baseCnt_d[15:8] = wData_q[15:8];
                  curCnt_d[15:8] = wData_q[15:8];
               end
            end
            IDX_PAGE: begin
               if (wStrb_q[0]) page_d = wData_q[7:0];
            end
            IDX_STATUS: begin
               if (wStrb_q[0]) cmdDis_d = wData_q[CMD_DIS_BIT];
            end
            IDX_SW_REQ: begin
               swReq_d = 1'b1;
            end
            IDX_MODE: begin
               if (wStrb_q[0]) begin
                  modeSel_d = cdma_mode_t'(wData_q[MODE_SEL_LSB +: 2]);
                  addrDec_d = wData_q[MODE_DEC_BIT];
                  autoReload_d = wData_q[MODE_AUTO_BIT];
                  xtype_d = cdma_xtype_t'(wData_q[MODE_TYPE_LSB +: 2]);
               end
            end
            IDX_CFG: begin
               if (wStrb_q[0]) wide_d = wData_q[CFG_WIDE_BIT];
            end
            IDX_MCLR, IDX_MASK: begin
            end
            default: bresp_d = RESP_SLVERR;
         endcase
      end

      // Read answers are registered; the status read side effect is below.
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (rdFire) begin
         rvalid_d = 1'b1;
         rresp_d = RESP_OKAY;
         rdata_d = 32'h0000_0000;
         unique case (arIdx)
            IDX_CUR_ADDR: rdata_d[15:0] = curAddr_q;
            IDX_PAGE: rdata_d[7:0] = page_q;
            IDX_CUR_CNT: rdata_d[15:0] = curCnt_q;
            IDX_STATUS: rdata_d[7:0] = {{4{reqF_q}}, {4{tc_q}}};
            IDX_MODE: rdata_d[7:0] = {modeSel_q, addrDec_q, autoReload_q, xtype_q, 2'b00};
            IDX_MASK: rdata_d[MASK_BIT] = mask_q;
            IDX_CFG: begin
               rdata_d[CMD_DIS_BIT] = cmdDis_q;
               rdata_d[CFG_WIDE_BIT] = wide_q;
            end
            IDX_SW_REQ, IDX_MCLR: begin
            end
            default: rresp_d = RESP_SLVERR;
         endcase
      end
      if (rdStatus) tc_d = 1'b0;

      // Transfer sequencer.
      unique case (state_q)
         ST_IDLE: begin
            if (canRun && (effReq || swReq_q)) begin
               state_d = ST_ISSUE;
               xfer_d = mkXfer(curAddr_q);
            end
         end
         ST_ISSUE: begin
            if (xferDone) begin
               curAddr_d = nextAddr;
               curCnt_d = nextCnt;
               xfer_d = mkXfer(nextAddr);
               if (tcHit) begin
                  tc_d = 1'b1;
                  // A software request written in this cycle survives the end of the block.
                  swReq_d = wrFire && (awIdx_q == IDX_SW_REQ);
                  if (autoReload_q) begin
                     curAddr_d = baseAddr_q;
                     curCnt_d = baseCnt_q;
                     xfer_d = mkXfer(baseAddr_q);
                  end
               end
               if (modeSel_q == MODE_BLOCK && !tcHit && canRun) begin
                  state_d = ST_ISSUE;
               end else if (modeSel_q == MODE_SINGLE) begin
                  state_d = ST_HOLD;
               end else begin
                  state_d = ST_IDLE;
               end
            end
         end
         ST_HOLD: begin
            if (!reqF_q) state_d = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase

      if (mclr) begin
         curAddr_d = RST_WORD;
         baseAddr_d = RST_WORD;
         curCnt_d = RST_WORD;
         baseCnt_d = RST_WORD;
         page_d = RST_BYTE;
         cmdDis_d = 1'b0;
         wide_d = 1'b0;
         modeSel_d = MODE_DEMAND;
         addrDec_d = 1'b0;
         autoReload_d = 1'b0;
         xtype_d = TYPE_NONE;
         mask_d = 1'b0;
         tc_d = 1'b0;
         swReq_d = 1'b0;
         if (state_q != ST_ISSUE) state_d = ST_IDLE;
      end

      // A removal in the same cycle as a master clear still masks the socket.
      // removal sets mask
      if (presF_q && !presF_d) mask_d = 1'b1;
   end

   // ==========================================================
   // Registers
   // ==========================================================
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reqSync_q <= 3'h0;
         presSync_q <= 3'h0;
         reqF_q <= 1'b0;
         presF_q <= 1'b0;
         curAddr_q <= RST_WORD;
         baseAddr_q <= RST_WORD;
         curCnt_q <= RST_WORD;
         baseCnt_q <= RST_WORD;
         page_q <= RST_BYTE;
         cmdDis_q <= 1'b0;
         wide_q <= 1'b0;
         modeSel_q <= MODE_DEMAND;
         addrDec_q <= 1'b0;
         autoReload_q <= 1'b0;
         xtype_q <= TYPE_NONE;
         mask_q <= 1'b0;
         tc_q <= 1'b0;
         swReq_q <= 1'b0;
         state_q <= ST_IDLE;
         xfer_q <= '0;
         awHeld_q <= 1'b0;
         awIdx_q <= 6'h00;
         wHeld_q <= 1'b0;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else begin
         reqSync_q <= reqSync_d;
         presSync_q <= presSync_d;
         reqF_q <= reqF_d;
         presF_q <= presF_d;
         curAddr_q <= curAddr_d;
         baseAddr_q <= baseAddr_d;
         curCnt_q <= curCnt_d;
         baseCnt_q <= baseCnt_d;
         page_q <= page_d;
         cmdDis_q <= cmdDis_d;
         wide_q <= wide_d;
         modeSel_q <= modeSel_d;
         addrDec_q <= addrDec_d;
         autoReload_q <= autoReload_d;
         xtype_q <= xtype_d;
         mask_q <= mask_d;
         tc_q <= tc_d;
         swReq_q <= swReq_d;
         state_q <= state_d;
         xfer_q <= xfer_d;
         awHeld_q <= awHeld_d;
         awIdx_q <= awIdx_d;
         wHeld_q <= wHeld_d;
         wData_q <= wData_d;
         wStrb_q <= wStrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

endmodule // cdma_channel

`default_nettype wire

// ===== test/cdma_engine_model.sv
// Bus-master engine model that takes offered transfers.
// Assumes the channel holds xferValid and xferReq until taken.
`timescale 1ns/1ps
`default_nettype none
module cdma_engine_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Transfer link
   input wire logic xferValid,
   output logic xferReady,
   // Cycles of delay before each take
   input wire logic [1:0] lag
);
   logic [1:0] waitQ;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         waitQ <= 2'h0;
      end else if (!xferValid || xferReady) begin
         waitQ <= 2'h0;
      end else begin
         waitQ <= waitQ + 2'h1;
      end
   end
   assign xferReady = xferValid && (waitQ >= lag);
endmodule // cdma_engine_model
`default_nettype wire

// ===== test/cdma_channel_chk.sv
// Concurrent checks on the register bus and transfer link of the channel.
// Assumes it is bound to cdma_channel and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cdma_channel_chk
   import cdma_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register bus
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Transfer link
   input wire logic xferValid,
   input wire logic xferReady,
   input wire cdma_xfer_t xferReq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic arTake;
   assign arTake = s_axi_arvalid && s_axi_arready;
   // ==========================================================
   // Register bus
   property p_rd_answer; arTake |=> s_axi_rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_ar_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_refuse: assert property (p_ar_refuse) else $error("address taken while busy");
   property p_stat_req; arTake && s_axi_araddr[7:2] == IDX_STATUS |=>
      s_axi_rdata[7:4] inside {4'h0, 4'hF} && s_axi_rdata[31:8] == 24'h00_0000; endproperty
   a_stat_req: assert property (p_stat_req) else $error("request bits split");
   property p_stat_tc; arTake && s_axi_araddr[7:2] == IDX_STATUS |=>
      s_axi_rdata[3:0] inside {4'h0, 4'hF}; endproperty
   a_stat_tc: assert property (p_stat_tc) else $error("terminal count bits split");
   property p_mode_low; arTake && s_axi_araddr[7:2] == IDX_MODE |=>
      s_axi_rdata[1:0] == 2'h0 && s_axi_rdata[31:8] == 24'h00_0000; endproperty
   a_mode_low: assert property (p_mode_low) else $error("mode low bits set");
   property p_unmapped; arTake && s_axi_araddr[7:2] == 6'h3F |=>
      s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
   // ==========================================================
   // Transfer link
   property p_x_hold; xferValid && !xferReady |=> xferValid && $stable(xferReq); endproperty
   a_x_hold: assert property (p_x_hold) else $error("offered transfer changed");
endmodule // cdma_channel_chk
bind cdma_channel cdma_channel_chk cdma_channel_chk_i (.clk, .rst_n, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .xferValid, .xferReady, .xferReq);
`default_nettype wire

// ===== test/cdma_channel_tb.sv
// Self-checking bench for the card socket DMA channel.
// Assumes the bound checker and the engine model beside the design.
`timescale 1ns/1ps
`default_nettype none
module cdma_channel_tb;
   import cdma_pkg::*;
   logic clk, rst_n, cardReq, cardPresent, xferValid, xferReady;
   logic [7:0] s_axi_awaddr, s_axi_araddr, v;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, lag;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   cdma_xfer_t xferReq;
   int mismatches, cmp_count, cyc, nXfer, cur, base, cnt, bcnt, page, step;
   bit wide, dec, autoRl, toMem, tcSeen;
   logic [5:0] idxList[7] = '{IDX_CUR_ADDR, IDX_PAGE, IDX_CUR_CNT, IDX_STATUS, IDX_MODE,
      IDX_MASK, IDX_CFG};
   cdma_channel cdma_channel_i (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .cardReq, .cardPresent, .xferValid, .xferReady, .xferReq);
   cdma_engine_model cdma_engine_model_i (.clk, .rst_n, .xferValid, .xferReady, .lag);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ==========================================================
   // Checking and bus tasks
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         summarize();
      end
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [5:0] i, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      bit a, w, b;
      {a, w, b} = 3'b000;
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!b) begin
         @(negedge clk);
         a = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         if (b) chk("bresp", s_axi_bresp, er);
         @(posedge clk);
         if (a) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
   endtask
   task automatic rd(input logic [5:0] i, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
      bit a, r;
      r = 1'b0;
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      while (!r) begin
         @(negedge clk);
         a = s_axi_arvalid && s_axi_arready;
         r = s_axi_rvalid;
         if (r) chk($sformatf("rdata %h", i), s_axi_rdata, e);
         if (r) chk("rresp", s_axi_rresp, er);
         @(posedge clk);
         if (a) s_axi_arvalid <= 1'b0;
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic fin(input string n);
      $display("test %s done", n);
   endtask
   task automatic stat(input bit req);
      rd(IDX_STATUS, {24'h00_0000, req ? 4'hF : 4'h0, tcSeen ? 4'hF : 4'h0});
      tcSeen = 1'b0;
   endtask
   task automatic mode(input logic [7:0] m);
      wr(IDX_MODE, {24'h00_0000, m});
      dec = m[MODE_DEC_BIT];
      autoRl = m[MODE_AUTO_BIT];
      toMem = m[3:2] == 2'b01;
   endtask
   task automatic mclr();
      wr(IDX_MCLR, $urandom);
      {cur, base, cnt, bcnt, page} = '0;
      {wide, dec, autoRl, toMem, tcSeen} = '0;
   endtask
   task automatic load(input int c);
      base = $urandom & 32'h0000_FFFF;
      cur = base;
      page = $urandom & 32'h0000_00FF;
      cnt = c;
      bcnt = c;
      wr(IDX_CUR_ADDR, base);
      wr(IDX_PAGE, page);
      wr(IDX_CUR_CNT, c);
      nXfer = 0;
   endtask
   // ==========================================================
   // Reference model of the transfer sequence
   always @(negedge clk) begin
      if (rst_n && xferValid && xferReady) begin
         step = wide ? 2 : 1;
         nXfer++;
         chk("xferAddr", xferReq.addr,
            wide ? {page[7:1], cur[15:0], 1'b0} : {page[7:0], cur[15:0]});
         chk("toMemory", xferReq.toMemory, toMem);
         chk("wide", xferReq.wide, wide);
         tcSeen |= cnt <= step;
         if (autoRl && cnt <= step) begin
            cur = base;
            cnt = bcnt;
         end else begin
            cur = (dec ? cur - step : cur + step) & 32'h0000_FFFF;
            cnt = (cnt - step) & 32'h0000_FFFF;
         end
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(91788));
      rst_n = 1'b0;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
      {s_axi_araddr, s_axi_arvalid, cardReq, lag} = '0;
      // Both response readies stay high so that back-to-back calls never drive them twice.
      {s_axi_bready, s_axi_rready} = 2'b11;
      s_axi_wstrb = 4'hF;
      cardPresent = 1'b1;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (idxList[k]) rd(idxList[k], 32'h0000_0000);
      rd(6'h3F, 32'h0000_0000, RESP_SLVERR);
      wr(6'h3F, $urandom, RESP_SLVERR);
      fin("defaults");
      for (int k = 0; k < 16; k++) begin
         v = 8'($urandom);
         v[7:6] = k[3:2];
         v[3:2] = k[1:0];
         wr(IDX_MODE, {24'h00_0000, v});
         rd(IDX_MODE, {24'h00_0000, v & 8'hFC});
      end
      mode(8'h00);
      wr(IDX_STATUS, 32'h0000_00FF);
      rd(IDX_CFG, 32'h0000_0004);
      rd(IDX_STATUS, 32'h0000_0000);
      wr(IDX_STATUS, 32'h0000_00FB);
      rd(IDX_CFG, 32'h0000_0000);
      fin("fields");
      cardPresent <= 1'b0;
      idle(8);
      cardReq <= 1'b1;
      mode(8'h04);
      idle(20);
      rd(IDX_MASK, 32'h0000_0001);
      chk("nXfer", nXfer, 0);
      stat(1'b1);
      mclr();
      rd(IDX_MASK, 32'h0000_0000);
      cardPresent <= 1'b1;
      wr(IDX_STATUS, 32'h0000_0004);
      mode(8'h84);
      wr(IDX_SW_REQ, $urandom);
      idle(20);
      chk("nXfer", nXfer, 0);
      mclr();
      rd(IDX_CFG, 32'h0000_0000);
      cardReq <= 1'b0;
      fin("mask and disable");
      lag <= 2'($urandom);
      load(3);
      mode(8'h14);
      cardReq <= 1'b1;
      repeat (300) if (nXfer < 7) @(posedge clk);
      wr(IDX_STATUS, 32'h0000_0004);
      cardReq <= 1'b0;
      idle(10);
      stat(1'b0);
      stat(1'b0);
      rd(IDX_CUR_ADDR, cur);
      rd(IDX_CUR_CNT, cnt);
      mclr();
      fin("demand reload");
      lag <= 2'($urandom);
      wr(IDX_CFG, 32'h0000_0001);
      wide = 1'b1;
      load(6);
      mode(8'hA8);
      wr(IDX_SW_REQ, $urandom);
      repeat (300) if (nXfer < 3) @(posedge clk);
      idle(20);
      chk("nXfer", nXfer, 3);
      stat(1'b0);
      rd(IDX_CUR_ADDR, cur);
      rd(IDX_CUR_CNT, cnt);
      fin("block wide");
      mclr();
      lag <= 2'($urandom);
      load(2);
      mode(8'h44);
      cardReq <= 1'b1;
      idle(20);
      chk("nXfer", nXfer, 1);
      cardReq <= 1'b0;
      idle(8);
      cardReq <= 1'b1;
      idle(20);
      chk("nXfer", nXfer, 2);
      cardReq <= 1'b0;
      rd(IDX_CUR_CNT, cnt);
      mclr();
      stat(1'b0);
      fin("single");
      summarize();
   end
endmodule // cdma_channel_tb
`default_nettype wire
